/* src/eeprom_pkg.sv */
// Shared constants for the serial nonvolatile memory link
package eeprom_pkg;
    localparam int          WORDS        = 256;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 16;
    localparam logic [3:0]  START_PAT    = 4'hA;
    localparam logic [7:0]  OP_READ      = 8'hA8;
    localparam logic [7:0]  OP_WRITE     = 8'hA4;
    localparam logic [7:0]  OP_EW_ENABLE = 8'hA3;
    localparam logic [7:0]  OP_EW_DISABLE = 8'hA0;
    localparam logic [7:0]  OP_FILL_ALL  = 8'hA1;
    localparam logic [5:0]  CMD_CLOCKS   = 6'h10;
    localparam logic [5:0]  FRAME_CLOCKS = 6'h20;
    localparam logic [15:0] CLEAR_WORD   = 16'hFFFF;
    localparam int          CLK_NS       = 8;
    localparam int          PROG_NS      = 5_000_000;
    localparam int          PROG_CYCLES  = PROG_NS / CLK_NS;
    localparam int          LINK_HALF_NS = 40;
    localparam int          LINK_HALF_CYCLES = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int          PWR_READ_NS  = 10_000;
    localparam int          PWR_READ_CYCLES = (PWR_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int          PWR_PROG_NS  = 1_000_000;
    localparam int          PWR_PROG_CYCLES = (PWR_PROG_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        CMD_RD        = 3'b000,
        CMD_WR        = 3'b001,
        CMD_EW_ENABLE = 3'b010,
        CMD_EW_DISABLE = 3'b011,
        CMD_FILL_ALL  = 3'b100
    } host_cmd_e;
endpackage : eeprom_pkg

/* src/eeprom_link_if.sv */
// Serial link between the host controller and the memory device
`timescale 1ns/1ns
`default_nettype none
interface eeprom_link_if;
    logic cs_n;
    logic serial_clock_in;
    logic serial_in;
    logic write_abort;
    logic serial_out;
    logic serial_out_oe;
    logic ready_busy_n;
    logic serial_line;
    // Undriven line reads low
    assign serial_line = serial_out_oe & serial_out;
    modport device (
        input  cs_n, serial_clock_in, serial_in, write_abort,
        output serial_out, serial_out_oe, ready_busy_n
    );
    modport host (
        output cs_n, serial_clock_in, serial_in, write_abort,
        input  serial_line, ready_busy_n
    );
endinterface : eeprom_link_if
`default_nettype wire

/* src/eeprom_device.sv */
// Memory device end: frame decoder, word array and self-timed writer
`timescale 1ns/1ns
`default_nettype none
module eeprom_device #(
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
    input  wire logic            CORE_CLK,
    input  wire logic            SRST,
    eeprom_link_if.device        link,
    output logic                 WRITE_ENABLED,
    output logic                 BUSY
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HUNT  = 3'b001,
        ST_FRAME = 3'b010,
        ST_READ  = 3'b011,
        ST_HOLD  = 3'b100
    } dev_state_e;

    logic [15:0] mem [eeprom_pkg::WORDS];
    logic [1:0]  cs_sync;
    logic [1:0]  sck_sync;
    logic [1:0]  si_sync;
    logic [1:0]  abort_sync;
    logic        sck_prev;
    logic        cs_prev;
    dev_state_e  state;
    logic [31:0] shift;
    logic [5:0]  clk_cnt;
    logic [15:0] rd_shift;
    logic [4:0]  rd_left;
    logic        rd_armed;
    logic        killed;
    logic        busy;
    logic        fill_mode;
    logic [7:0]  prog_addr;
    logic [15:0] prog_data;
    logic [31:0] prog_cnt;
    logic        status_pending;
    logic        we_enabled;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_fall;
    logic        cs_low;
    logic        abort;
    logic        si;
    logic [31:0] next_shift;
    logic [7:0]  opcode;
    logic        frame_done;

    // Link pins come from the host's domain
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cs_sync    <= 2'h3;
            sck_sync   <= 2'h0;
            si_sync    <= 2'h0;
            abort_sync <= 2'h0;
            sck_prev   <= 1'b0;
            cs_prev    <= 1'b1;
        end else begin
            cs_sync    <= {cs_sync[0], link.cs_n};
            sck_sync   <= {sck_sync[0], link.serial_clock_in};
            si_sync    <= {si_sync[0], link.serial_in};
            abort_sync <= {abort_sync[0], link.write_abort};
            sck_prev   <= sck_sync[1];
            cs_prev    <= cs_sync[1];
        end
    end

    assign sck_rise   = sck_sync[1] & ~sck_prev;
    assign sck_fall   = ~sck_sync[1] & sck_prev;
    assign cs_fall    = ~cs_sync[1] & cs_prev;
    assign cs_low     = ~cs_sync[1];
    assign abort      = abort_sync[1];
    assign si         = si_sync[1];
    assign next_shift = {shift[30:0], si};
    assign opcode     = next_shift[15:8];
    assign frame_done = sck_rise && (clk_cnt == eeprom_pkg::FRAME_CLOCKS - 6'h1);

    // Frame decoder
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state    <= ST_IDLE;
            shift    <= 32'h0000_0000;
            clk_cnt  <= 6'h00;
            rd_armed <= 1'b0;
            killed   <= 1'b0;
        end else if (!cs_low) begin
            state    <= ST_IDLE;
            rd_armed <= 1'b0;
        end else if (cs_fall) begin
            // Fresh selection restarts the hunt; busy frames are ignored
            state   <= busy ? ST_HOLD : ST_HUNT;
            shift   <= 32'h0000_0000;
            clk_cnt <= 6'h00;
            killed  <= 1'b0;
        end else begin
            if (abort && state == ST_FRAME) begin
                killed <= 1'b1;
            end
            case (state)
                ST_HUNT: begin
                    if (sck_rise) begin
                        shift <= next_shift;
                        if (next_shift[3:0] == eeprom_pkg::START_PAT) begin
                            state   <= ST_FRAME;
                            clk_cnt <= 6'h04;
                        end
                    end
                end
                ST_FRAME: begin
                    if (sck_rise) begin
                        shift   <= next_shift;
                        clk_cnt <= clk_cnt + 6'h01;
                        if (clk_cnt == eeprom_pkg::CMD_CLOCKS - 6'h1) begin
                            if (opcode == eeprom_pkg::OP_READ) begin
                                state    <= ST_READ;
                                rd_armed <= 1'b1;
                            end else if (opcode != eeprom_pkg::OP_WRITE
                                         && opcode != eeprom_pkg::OP_FILL_ALL) begin
                                state <= ST_HOLD;
                            end
                        end else if (frame_done) begin
                            state <= ST_HOLD;
                        end
                    end
                end
                ST_READ: begin
                    if (sck_fall) begin
                        rd_armed <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Write enable latch; the abort pin never touches it
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            we_enabled <= 1'b0;
        end else if (state == ST_FRAME && sck_rise
                     && clk_cnt == eeprom_pkg::CMD_CLOCKS - 6'h1) begin
            if (opcode == eeprom_pkg::OP_EW_ENABLE) begin
                we_enabled <= 1'b1;
            end else if (opcode == eeprom_pkg::OP_EW_DISABLE) begin
                we_enabled <= 1'b0;
            end
        end
    end

    // Self-timed clear then program
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            busy           <= 1'b0;
            fill_mode      <= 1'b0;
            prog_addr      <= 8'h00;
            prog_data      <= 16'h0000;
            prog_cnt       <= 32'h0000_0000;
            status_pending <= 1'b0;
        end else if (busy) begin
            if (abort) begin
                // Word may be left cleared to CLEAR_WORD but not yet programmed
                busy           <= 1'b0;
                status_pending <= 1'b1;
            end else if (prog_cnt == 32'(PROG_CYCLES - 1)) begin
                busy           <= 1'b0;
                status_pending <= 1'b1;
            end else begin
                prog_cnt <= prog_cnt + 32'h0000_0001;
            end
        end else if (state == ST_FRAME && frame_done && !killed && !abort
                     && we_enabled) begin
            busy           <= 1'b1;
            // Whole frame is in next_shift on the last rise
            fill_mode      <= next_shift[31:24] == eeprom_pkg::OP_FILL_ALL;
            prog_addr      <= next_shift[23:16];
            prog_data      <= next_shift[15:0];
            prog_cnt       <= 32'h0000_0000;
            status_pending <= 1'b0;
        end else if (status_pending && cs_low && sck_rise && si) begin
            status_pending <= 1'b0;
        end
    end

    // Clear at the start of the cycle, program at its midpoint
    always_ff @(posedge CORE_CLK) begin
        if (busy && !abort && (prog_cnt == 32'h0000_0000
                               || prog_cnt == 32'(PROG_CYCLES / 2))) begin
            for (int i = 0; i < eeprom_pkg::WORDS; i++) begin
                if (fill_mode || prog_addr == 8'(i)) begin
                    mem[i] <= prog_cnt == 32'h0000_0000 ? eeprom_pkg::CLEAR_WORD : prog_data;
                end
            end
        end
    end

    // Read data shifter
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rd_shift <= 16'h0000;
            rd_left  <= 5'h00;
        end else if (state == ST_FRAME && sck_rise
                     && clk_cnt == eeprom_pkg::CMD_CLOCKS - 6'h1) begin
            rd_shift <= mem[next_shift[7:0]];
            rd_left  <= 5'h10;
        end else if (!cs_low) begin
            rd_left <= 5'h00;
        end else if (state == ST_READ && sck_fall && rd_left != 5'h00) begin
            rd_shift <= rd_armed ? rd_shift : {rd_shift[14:0], 1'b0};
            rd_left  <= rd_armed ? rd_left : rd_left - 5'h01;
        end
    end

    // Pin drivers
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            link.serial_out    <= 1'b0;
            link.serial_out_oe <= 1'b0;
            link.ready_busy_n  <= 1'b1;
            WRITE_ENABLED      <= 1'b0;
            BUSY               <= 1'b0;
        end else begin
            link.ready_busy_n <= ~busy;
            WRITE_ENABLED     <= we_enabled;
            BUSY              <= busy;
            if (!cs_low) begin
                link.serial_out_oe <= 1'b0;
                link.serial_out    <= 1'b0;
            end else if (busy || status_pending) begin
                link.serial_out_oe <= 1'b1;
                link.serial_out    <= ~busy;
            end else if (state == ST_READ && !rd_armed && rd_left != 5'h00) begin
                link.serial_out_oe <= 1'b1;
                link.serial_out    <= rd_shift[15];
            end else begin
                link.serial_out_oe <= 1'b0;
                link.serial_out    <= 1'b0;
            end
        end
    end
endmodule : eeprom_device
`default_nettype wire

/* src/eeprom_host.sv */
// Host controller end: frame builder, clock divider, status poll, read buffer
`timescale 1ns/1ns
`default_nettype none
module eeprom_host #(
    parameter int HALF_CYCLES = eeprom_pkg::LINK_HALF_CYCLES,
    parameter int PWR_PROG_CYCLES = eeprom_pkg::PWR_PROG_CYCLES
) (
    input  wire logic                   CORE_CLK,
    input  wire logic                   SRST,
    eeprom_link_if.host                 link,
    input  wire logic                   CMD_VALID,
    output logic                        CMD_READY,
    input  wire eeprom_pkg::host_cmd_e  CMD_OP,
    input  wire logic [7:0]             CMD_ADDR,
    input  wire logic [15:0]            CMD_DATA,
    input  wire logic                   ABORT,
    output logic                        RD_VALID,
    input  wire logic                   RD_READY,
    output logic [15:0]                 RD_DATA,
    output logic                        DEV_READY
);
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_SEL   = 3'b001,
        H_SHIFT = 3'b010,
        H_END   = 3'b011,
        H_POLL  = 3'b100
    } host_state_e;

    host_state_e state;
    logic [31:0] frame;
    logic [5:0]  clk_cnt;
    logic [5:0]  nclk;
    logic        is_read;
    logic        is_write;
    logic [15:0] rd_word;
    logic [15:0] half_cnt;
    logic        tick;
    logic [31:0] pwr_cnt;
    logic [1:0]  line_sync;
    logic [1:0]  rb_sync;
    logic [15:0] buf_mem [2];
    logic        buf_wp;
    logic        buf_rp;
    logic [1:0]  buf_cnt;
    logic        push;
    logic        pop;
    logic [1:0]  next_cnt;
    logic [7:0]  op_code;
    logic        pwr_read_ok;
    logic        pwr_prog_ok;
    logic        can_take;

    // One-cycle enable per half link period
    always_ff @(posedge CORE_CLK) begin
        if (SRST || half_cnt == 16'(HALF_CYCLES - 1)) begin
            half_cnt <= 16'h0000;
        end else begin
            half_cnt <= half_cnt + 16'h0001;
        end
    end
    assign tick = half_cnt == 16'(HALF_CYCLES - 1);

    // Power-up wait before read and program
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pwr_cnt <= 32'h0000_0000;
        end else if (!pwr_prog_ok || !pwr_read_ok) begin
            pwr_cnt <= pwr_cnt + 32'h0000_0001;
        end
    end
    // Either wait may be the longer one, so count until both are met
    assign pwr_read_ok = pwr_cnt >= 32'(eeprom_pkg::PWR_READ_CYCLES);
    assign pwr_prog_ok = pwr_cnt >= 32'(PWR_PROG_CYCLES);

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            line_sync <= 2'h0;
            rb_sync   <= 2'h0;
        end else begin
            line_sync <= {line_sync[0], link.serial_line};
            rb_sync   <= {rb_sync[0], link.ready_busy_n};
        end
    end

    always_comb begin
        case (CMD_OP)
            eeprom_pkg::CMD_RD:         op_code = eeprom_pkg::OP_READ;
            eeprom_pkg::CMD_WR:         op_code = eeprom_pkg::OP_WRITE;
            eeprom_pkg::CMD_EW_ENABLE:  op_code = eeprom_pkg::OP_EW_ENABLE;
            eeprom_pkg::CMD_EW_DISABLE: op_code = eeprom_pkg::OP_EW_DISABLE;
            default:                    op_code = eeprom_pkg::OP_FILL_ALL;
        endcase
    end

    // A read is taken only with room in the buffer, so the receiver can stall
    assign can_take = state == H_IDLE && pwr_read_ok && buf_cnt != 2'h2
                      && (pwr_prog_ok || CMD_OP == eeprom_pkg::CMD_RD);
    assign push     = state == H_END && tick && is_read;
    assign pop      = RD_VALID && RD_READY;
    assign next_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state                <= H_IDLE;
            frame                <= 32'h0000_0000;
            clk_cnt              <= 6'h00;
            nclk                 <= 6'h00;
            is_read              <= 1'b0;
            is_write             <= 1'b0;
            rd_word              <= 16'h0000;
            CMD_READY            <= 1'b0;
            link.cs_n            <= 1'b1;
            link.serial_clock_in <= 1'b0;
            link.serial_in       <= 1'b0;
        end else begin
            CMD_READY <= can_take && !(CMD_VALID && CMD_READY);
            case (state)
                H_IDLE: begin
                    if (CMD_VALID && CMD_READY) begin
                        frame    <= {op_code, CMD_ADDR, CMD_DATA};
                        nclk     <= (CMD_OP == eeprom_pkg::CMD_EW_ENABLE
                                     || CMD_OP == eeprom_pkg::CMD_EW_DISABLE)
                                    ? eeprom_pkg::CMD_CLOCKS : eeprom_pkg::FRAME_CLOCKS;
                        is_read  <= CMD_OP == eeprom_pkg::CMD_RD;
                        is_write <= CMD_OP == eeprom_pkg::CMD_WR || CMD_OP == eeprom_pkg::CMD_FILL_ALL;
                        clk_cnt  <= 6'h00;
                        state    <= H_SEL;
                    end
                end
                H_SEL: begin
                    if (tick) begin
                        link.cs_n      <= 1'b0;
                        link.serial_in <= frame[31];
                        state          <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tick) begin
                        if (!link.serial_clock_in) begin
                            link.serial_clock_in <= 1'b1;
                            clk_cnt              <= clk_cnt + 6'h01;
                        end else begin
                            link.serial_clock_in <= 1'b0;
                            frame                <= {frame[30:0], 1'b0};
                            link.serial_in       <= frame[30];
                            // Sampled late in the high phase to cover both sync delays
                            if (is_read && clk_cnt > eeprom_pkg::CMD_CLOCKS) begin
                                rd_word <= {rd_word[14:0], line_sync[1]};
                            end
                            if (clk_cnt == nclk) begin
                                state <= H_END;
                            end
                        end
                    end
                end
                H_END: begin
                    if (tick) begin
                        link.cs_n      <= 1'b1;
                        link.serial_in <= 1'b0;
                        state          <= is_write ? H_POLL : H_IDLE;
                    end
                end
                default: begin
                    // Poll status on the data line after a fresh select
                    if (tick) begin
                        if (link.cs_n) begin
                            link.cs_n <= 1'b0;
                        end else if (line_sync[1] || rb_sync[1] || ABORT) begin
                            // Pin ends it too: a refused write never drives the line
                            link.cs_n <= 1'b1;
                            state     <= H_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Two-entry read buffer
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            buf_wp   <= 1'b0;
            buf_rp   <= 1'b0;
            buf_cnt  <= 2'h0;
            RD_VALID <= 1'b0;
            RD_DATA  <= 16'h0000;
        end else begin
            if (push) begin
                buf_mem[buf_wp] <= rd_word;
                buf_wp          <= ~buf_wp;
            end
            if (pop) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt  <= next_cnt;
            RD_VALID <= next_cnt != 2'h0;
            if (pop) begin
                RD_DATA <= buf_cnt == 2'h2 ? buf_mem[~buf_rp] : rd_word;
            end else if (buf_cnt == 2'h0) begin
                RD_DATA <= rd_word;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            link.write_abort <= 1'b0;
            DEV_READY        <= 1'b0;
        end else begin
            link.write_abort <= ABORT;
            DEV_READY        <= rb_sync[1];
        end
    end
endmodule : eeprom_host
`default_nettype wire

/* bench/eeprom_link_monitor.sv */
// Link protocol checker between host and memory ends
`timescale 1ns/1ns
`default_nettype none
module eeprom_link_monitor #(
    parameter int PROG_CYCLES = 64
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic cs_n,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic write_abort,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic ready_busy_n
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    logic [19:0] low_cnt;
    logic        aborted;
    // Abort seen since the pin was last ready excuses a short busy
    always_ff @(posedge CORE_CLK) begin
        if (SRST || (ready_busy_n && !write_abort)) begin
            aborted <= 1'b0;
        end else if (write_abort) begin
            aborted <= 1'b1;
        end
    end
    // Counter instead of a long repetition keeps the tools fast
    always_ff @(posedge CORE_CLK) begin
        if (SRST || ready_busy_n) begin
            low_cnt <= 20'h0_0000;
        end else begin
            low_cnt <= low_cnt + 20'h0_0001;
        end
    end
    chk_idle_after_reset: assert property ($fell(SRST) |-> ready_busy_n && !serial_out_oe)
        else $error("link not idle after reset");
    chk_hiz_deselected: assert property (cs_n [*5] |-> !serial_out_oe)
        else $error("output driven while deselected");
    chk_drive_selected: assert property ($rose(serial_out_oe) |-> !cs_n)
        else $error("output enabled without select");
    chk_busy_bounded: assert property (low_cnt <= PROG_CYCLES + 2)
        else $error("busy lasts too long");
    chk_busy_length: assert property ($rose(ready_busy_n) && !aborted |-> low_cnt == 20'(PROG_CYCLES))
        else $error("busy length wrong");
    chk_abort_ready: assert property ($rose(write_abort) && !ready_busy_n |-> ##[1:8] ready_busy_n)
        else $error("abort did not end busy");
    chk_status_busy: assert property (serial_out_oe && !ready_busy_n && !$past(ready_busy_n) |-> !serial_out)
        else $error("status not busy");
    chk_status_ready: assert property ($rose(ready_busy_n) && !cs_n && !write_abort
        |-> ##[0:6] (serial_out_oe && serial_out))
        else $error("ready not shown on output");
    cov_write: cover property ($fell(ready_busy_n));
    cov_read: cover property ($rose(serial_out_oe) && ready_busy_n);
    cov_abort: cover property (write_abort && !ready_busy_n);
endmodule : eeprom_link_monitor
`default_nettype wire

/* bench/testbench.sv */
// Both link ends joined, driven from the host user side
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %s", $time, m); end end
module testbench;
    typedef struct {eeprom_pkg::host_cmd_e op; logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_s;
    logic core_clk, srst, cmd_valid, cmd_ready, abort, rd_valid, rd_ready, dev_ready, write_enabled, busy, we;
    eeprom_pkg::host_cmd_e cmd_op;
    logic [7:0]  cmd_addr;
    logic [15:0] cmd_data, rd_data;
    int n_errors, cmp_count, cyc;
    row_s rows[12] = '{
        '{eeprom_pkg::CMD_EW_ENABLE, 8'h00, 16'h0000, 16'h0000}, '{eeprom_pkg::CMD_WR, 8'h00, 16'h1234, 16'h0000},
        '{eeprom_pkg::CMD_WR, 8'hFF, 16'hABCD, 16'h0000}, '{eeprom_pkg::CMD_RD, 8'h00, 16'h0000, 16'h1234},
        '{eeprom_pkg::CMD_RD, 8'hFF, 16'h0000, 16'hABCD}, '{eeprom_pkg::CMD_EW_DISABLE, 8'h00, 16'h0000, 16'h0000},
        '{eeprom_pkg::CMD_WR, 8'h00, 16'h5555, 16'h0000}, '{eeprom_pkg::CMD_RD, 8'h00, 16'h0000, 16'h1234},
        '{eeprom_pkg::CMD_EW_ENABLE, 8'h00, 16'h0000, 16'h0000}, '{eeprom_pkg::CMD_FILL_ALL, 8'h00, 16'h0F0F, 16'h0000},
        '{eeprom_pkg::CMD_RD, 8'h80, 16'h0000, 16'h0F0F}, '{eeprom_pkg::CMD_RD, 8'hFF, 16'h0000, 16'h0F0F}};
    eeprom_link_if eeprom_link_if_i ();
    eeprom_device #(.PROG_CYCLES(64)) eeprom_device_i (.CORE_CLK(core_clk), .SRST(srst), .link(eeprom_link_if_i),
        .WRITE_ENABLED(write_enabled), .BUSY(busy));
    eeprom_host #(.HALF_CYCLES(5), .PWR_PROG_CYCLES(200)) eeprom_host_i (.CORE_CLK(core_clk), .SRST(srst),
        .link(eeprom_link_if_i), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .ABORT(abort), .RD_VALID(rd_valid), .RD_READY(rd_ready),
        .RD_DATA(rd_data), .DEV_READY(dev_ready));
    eeprom_link_monitor #(.PROG_CYCLES(64)) eeprom_link_monitor_i (.CORE_CLK(core_clk), .SRST(srst),
        .cs_n(eeprom_link_if_i.cs_n), .serial_clock_in(eeprom_link_if_i.serial_clock_in),
        .serial_in(eeprom_link_if_i.serial_in), .write_abort(eeprom_link_if_i.write_abort),
        .serial_out(eeprom_link_if_i.serial_out), .serial_out_oe(eeprom_link_if_i.serial_out_oe),
        .ready_busy_n(eeprom_link_if_i.ready_busy_n));
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // Wait for idle first so a lowered valid is never raised in the same step
    task automatic issue(input eeprom_pkg::host_cmd_e op, input logic [7:0] a, input logic [15:0] d);
        do @(posedge core_clk); while (cmd_ready !== 1'b1);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
    endtask : issue
    task automatic pop(input logic [15:0] e);
        do @(posedge core_clk); while (rd_valid !== 1'b1);
        `CHK(rd_data, e, "read word")
        rd_ready <= 1'b1;
        @(posedge core_clk);
        rd_ready <= 1'b0;
    endtask : pop
    task automatic settle;
        do @(posedge core_clk); while (cmd_ready !== 1'b1);
    endtask : settle
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Ceiling well above the roughly 7000 cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        {cmd_valid, abort, rd_ready, we} = 4'h0;
        {cmd_addr, cmd_data} = 24'h00_0000;
        cmd_op = eeprom_pkg::CMD_RD;
        srst = 1'b1;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK(write_enabled, 1'b0, "enabled at power-up")
        `CHK(eeprom_link_if_i.serial_out_oe, 1'b0, "output driven after reset")
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].a, rows[i].d);
            if (rows[i].op == eeprom_pkg::CMD_RD) pop(rows[i].e);
            if (rows[i].op == eeprom_pkg::CMD_EW_ENABLE) we = 1'b1;
            if (rows[i].op == eeprom_pkg::CMD_EW_DISABLE) we = 1'b0;
            settle();
            `CHK(write_enabled, we, "enable latch")
        end
        // Receiver stalls: two words parked, third command held off
        issue(eeprom_pkg::CMD_RD, 8'h00, 16'h0000);
        issue(eeprom_pkg::CMD_RD, 8'h01, 16'h0000);
        repeat (600) @(posedge core_clk);
        `CHK(cmd_ready, 1'b0, "full buffer accepted command")
        // Fill has overwritten both words
        pop(16'h0F0F);
        pop(16'h0F0F);
        // Abort while programming
        issue(eeprom_pkg::CMD_WR, 8'h01, 16'h7777);
        do @(posedge core_clk); while (busy !== 1'b1);
        abort <= 1'b1;
        @(posedge core_clk);
        abort <= 1'b0;
        repeat (10) @(posedge core_clk);
        `CHK(eeprom_link_if_i.ready_busy_n, 1'b1, "abort left busy")
        // Abort in mid-frame discards the write
        issue(eeprom_pkg::CMD_WR, 8'h02, 16'h4444);
        repeat (120) @(posedge core_clk);
        abort <= 1'b1;
        @(posedge core_clk);
        abort <= 1'b0;
        // Lands where a wrongly started program cycle would still be busy
        repeat (230) @(posedge core_clk);
        `CHK(busy, 1'b0, "discarded write programmed")
        issue(eeprom_pkg::CMD_RD, 8'h02, 16'h0000);
        pop(16'h0F0F);
        settle();
        `CHK(dev_ready, 1'b1, "device not ready at end")
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
